/* File: i2crs_master.v */
/*
  Repeated-start sequencer of an I2C master, with start detection, bus
  collision detection, write-collision guard and control-register lockout.
  Assumes open-drain bus lines resolved outside; output enables are low
  while the block pulls a line low. Bus inputs are asynchronous.
*/
`timescale 1ns/1ns
`include "i2crs_defs.vh"

module i2crs_master
(
  input wire clock,
  input wire reset_n,
  input wire clk_en,
  input wire [7:0] ctl2_wdata,
  input wire ctl2_we,
  output wire [7:0] serial_control_two,
  input wire [6:0] baud_reload_value,
  input wire other_event_busy,
  input wire [7:0] buf_wdata,
  input wire buf_we,
  output wire [7:0] transmit_buffer,
  output wire start_seen,
  input wire start_seen_clr,
  output wire serial_irq_flag,
  input wire irq_clr,
  output wire write_collision_flag,
  input wire write_collision_flag_clr,
  output wire bus_collision_flag,
  input wire bcol_clr,
  output wire rs_busy,
  input wire bus_clock_line_in,
  output wire bus_clock_line_out,
  output wire bus_clock_line_oe,
  input wire bus_data_line_in,
  output wire bus_data_line_out,
  output wire bus_data_line_oe
);

  // ****************************************
  // States
  // ****************************************
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_SCL_LOW = 3'd1;
  localparam [2:0] ST_SDA_REL = 3'd2;
  localparam [2:0] ST_SCL_REL = 3'd3;
  localparam [2:0] ST_BOTH_HI = 3'd4;
  localparam [2:0] ST_SDA_LOW = 3'd5;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [7:0] ctl2_q;
  reg [7:0] buf_q;
  reg [6:0] brg_q;
  reg [6:0] brg_d;
  reg scl_drv_q;
  reg scl_drv_d;
  reg sda_drv_q;
  reg sda_drv_d;
  reg start_q;
  reg irq_q;
  reg write_collision_flag_q;
  reg bcol_q;
  reg done_d;
  reg coll_d;

  wire scl_lvl;
  wire scl_rise;
  wire scl_fall;
  wire sda_lvl;
  wire sda_fall;
  wire busy;
  wire brg_zero;
  wire rs_req;

  // ****************************************
  // Bus input synchronisers
  // ****************************************
  i2crs_sync u_scl_sync
  (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .async_in(bus_clock_line_in),
    .level(scl_lvl),
    .rise(scl_rise),
    .fall(scl_fall)
  );

  i2crs_sync u_sda_sync
  (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .async_in(bus_data_line_in),
    .level(sda_lvl),
    .rise(),
    .fall(sda_fall)
  );

  assign busy = (state_q != ST_IDLE);
  assign brg_zero = (brg_q == 7'h00);
  assign rs_req = ctl2_q[`I2CRS_CTL2_REPEATED_START_REQUEST_BIT];

  // ****************************************
  // Sequencer next state
  // ****************************************
  always @*
  begin
    state_d = state_q;
    brg_d = brg_zero ? brg_q : brg_q - 7'h01;
    scl_drv_d = scl_drv_q;
    sda_drv_d = sda_drv_q;
    done_d = 1'b0;
    coll_d = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (rs_req && !other_event_busy)
        begin
          scl_drv_d = 1'b1;
          sda_drv_d = 1'b0;
          state_d = ST_SCL_LOW;
        end
      end
      ST_SCL_LOW:
      begin
        if (!scl_lvl)
        begin
          brg_d = {1'b0, baud_reload_value[`I2CRS_BAUD_LOW_W-1:0]};
          state_d = ST_SDA_REL;
        end
      end
      ST_SDA_REL:
      begin
        if (brg_zero && sda_lvl)
        begin
          scl_drv_d = 1'b0;
          state_d = ST_SCL_REL;
        end
      end
      ST_SCL_REL:
      begin
        if (scl_rise && !sda_lvl)
          coll_d = 1'b1;
        else if (scl_lvl)
        begin
          brg_d = baud_reload_value;
          state_d = ST_BOTH_HI;
        end
      end
      ST_BOTH_HI:
      begin
        if (scl_fall || !sda_lvl)
          coll_d = 1'b1;
        else if (brg_zero)
        begin
          sda_drv_d = 1'b1;
          brg_d = baud_reload_value;
          state_d = ST_SDA_LOW;
        end
      end
      ST_SDA_LOW:
      begin
        if (scl_fall)
          coll_d = 1'b1;
        else if (brg_zero)
        begin
          done_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
        scl_drv_d = 1'b0;
        sda_drv_d = 1'b0;
      end
    endcase
    if (coll_d)
    begin
      state_d = ST_IDLE;
      scl_drv_d = 1'b0;
      sda_drv_d = 1'b0;
    end
  end

  // ****************************************
  // Sequencer registers
  // ****************************************
  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
      brg_q <= `I2CRS_BAUD_RESET;
      scl_drv_q <= 1'b0;
      sda_drv_q <= 1'b0;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
      brg_q <= brg_d;
      scl_drv_q <= scl_drv_d;
      sda_drv_q <= sda_drv_d;
    end
  end

  // ****************************************
  // Control register and transmit buffer
  // ****************************************
  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      ctl2_q <= `I2CRS_CTL2_RESET;
      buf_q <= `I2CRS_BUF_RESET;
    end
    else if (clk_en)
    begin
      // Events are not queued: low bits locked while busy
      if (ctl2_we && !busy)
      begin
        ctl2_q <= ctl2_wdata;
        if (other_event_busy)
          ctl2_q[`I2CRS_CTL2_REPEATED_START_REQUEST_BIT] <= 1'b0;
      end
      else if (ctl2_we)
        ctl2_q <= (ctl2_wdata & ~`I2CRS_CTL2_LOCK_MASK)
          | (ctl2_q & `I2CRS_CTL2_LOCK_MASK);
      // Request self-clears at the end, on an abort or when refused
      if (done_d || coll_d)
        ctl2_q[`I2CRS_CTL2_REPEATED_START_REQUEST_BIT] <= 1'b0;
      else if (state_q == ST_IDLE && rs_req && other_event_busy)
        ctl2_q[`I2CRS_CTL2_REPEATED_START_REQUEST_BIT] <= 1'b0;
      // Buffer write refused while the sequence runs
      if (buf_we && !busy)
        buf_q <= buf_wdata;
    end
  end

  // ****************************************
  // Status flags: an event wins over its clear
  // ****************************************
  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      start_q <= 1'b0;
      irq_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      bcol_q <= 1'b0;
    end
    else if (clk_en)
    begin
      // Start condition: data falls while clock high
      if (sda_fall && scl_lvl)
        start_q <= 1'b1;
      else if (start_seen_clr)
        start_q <= 1'b0;
      if (done_d)
        irq_q <= 1'b1;
      else if (irq_clr)
        irq_q <= 1'b0;
      if (buf_we && busy)
        write_collision_flag_q <= 1'b1;
      else if (write_collision_flag_clr)
        write_collision_flag_q <= 1'b0;
      if (coll_d)
        bcol_q <= 1'b1;
      else if (bcol_clr)
        bcol_q <= 1'b0;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign serial_control_two = ctl2_q;
  assign transmit_buffer = buf_q;
  assign start_seen = start_q;
  assign serial_irq_flag = irq_q;
  assign write_collision_flag = write_collision_flag_q;
  assign bus_collision_flag = bcol_q;
  assign rs_busy = busy;
  assign bus_clock_line_out = 1'b0;
  assign bus_clock_line_oe = ~scl_drv_q;
  assign bus_data_line_out = 1'b0;
  assign bus_data_line_oe = ~sda_drv_q;

endmodule

/* File: i2crs_defs.vh */
/*
  Constants for the I2C master repeated-start block: field positions,
  widths and reset values.
  Assumes inclusion by bare name from the design files.
*/
`ifndef I2CRS_DEFS_VH
`define I2CRS_DEFS_VH

// ****************************************
// Control field positions
// ****************************************
`define I2CRS_CTL2_W 8
`define I2CRS_CTL2_REPEATED_START_REQUEST_BIT 1
`define I2CRS_CTL2_LOCK_MASK 8'h1F
`define I2CRS_CTL2_RESET 8'h00
`define I2CRS_STAT_START_BIT 3

// ****************************************
// Baud reload fields
// ****************************************
`define I2CRS_BAUD_W 7
`define I2CRS_BAUD_LOW_W 6
`define I2CRS_BAUD_RESET 7'h00

// ****************************************
// Data widths
// ****************************************
`define I2CRS_BUF_W 8
`define I2CRS_BUF_RESET 8'h00

`endif

/* File: i2crs_sync.v */
/*
  Two-stage synchroniser with an edge detector on the synchronised level.
  Assumes the input is asynchronous to clock; output resets high (bus idle).
*/
`timescale 1ns/1ns
module i2crs_sync
(
  input wire clock,
  input wire reset_n,
  input wire clk_en,
  input wire async_in,
  output wire level,
  output wire rise,
  output wire fall
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end
    else if (clk_en)
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = clk_en & sync_q & ~prev_q;
  assign fall = clk_en & ~sync_q & prev_q;

endmodule

/* File: i2crs_master_assertions.sv */
/*
  Concurrent checks on the ports of the repeated-start sequencer.
  Assumes it is bound into i2crs_master; all checks use the block clock.
*/
`timescale 1ns/1ns
module i2crs_master_assertions
(
  input wire clock,
  input wire reset_n,
  input wire clk_en,
  input wire ctl2_we,
  input wire [7:0] serial_control_two,
  input wire buf_we,
  input wire [7:0] transmit_buffer,
  input wire serial_irq_flag,
  input wire write_collision_flag,
  input wire bus_collision_flag,
  input wire rs_busy,
  input wire bus_clock_line_oe,
  input wire bus_data_line_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n || !clk_en);

  property p_req;
    $rose(rs_busy) |-> serial_control_two[1];
  endproperty
  a_req: assert property (p_req) else $error("start without request");
  property p_scl;
    $rose(rs_busy) |-> ##[0:1] !bus_clock_line_oe;
  endproperty
  a_scl: assert property (p_scl) else $error("clock not pulled");
  property p_rel;
    $rose(bus_clock_line_oe) && rs_busy |-> bus_data_line_oe;
  endproperty
  a_rel: assert property (p_rel) else $error("data held at release");
  property p_low;
    $fell(bus_data_line_oe) |-> bus_clock_line_oe;
  endproperty
  a_low: assert property (p_low) else $error("data pulled, clock low");
  property p_irq;
    $rose(serial_irq_flag) |-> !serial_control_two[1] && !bus_data_line_oe;
  endproperty
  a_irq: assert property (p_irq) else $error("bad finish");
  property p_write_collision_flag;
    buf_we && rs_busy |=> write_collision_flag && $stable(transmit_buffer);
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("buffer write taken");
  property p_lock;
    ctl2_we && rs_busy |=> $stable(serial_control_two[4:2])
      && $stable(serial_control_two[0]);
  endproperty
  a_lock: assert property (p_lock) else $error("locked bits moved");
  property p_bcol;
    $rose(bus_collision_flag) |-> bus_clock_line_oe && bus_data_line_oe
      && !serial_control_two[1] && !$rose(serial_irq_flag);
  endproperty
  a_bcol: assert property (p_bcol) else $error("bad abort");
  c_irq: cover property ($rose(serial_irq_flag));
  c_bcol: cover property ($rose(bus_collision_flag));
  c_write_collision_flag: cover property (buf_we && rs_busy);
endmodule

/* File: i2crs_bus_model.sv */
/*
  Two-wire bus with pull-ups and a second master that may pull either line.
  Assumes the block's enables are low while it pulls a line low.
*/
`timescale 1ns/1ns
module i2crs_bus_model
(
  input wire bus_clock_line_oe,
  input wire bus_data_line_oe,
  input wire scl_pull,
  input wire sda_pull,
  output wire bus_clock_line_in,
  output wire bus_data_line_in
);
  // Wired-and: high unless some party pulls the line
  assign bus_clock_line_in = bus_clock_line_oe & ~scl_pull;
  assign bus_data_line_in = bus_data_line_oe & ~sda_pull;
endmodule

/* File: tb.sv */
/*
  Self-checking bench for the repeated-start sequencer.
  Assumes the bus model and the checker are compiled alongside.
*/
`timescale 1ns/1ns
module tb;
  reg clock = 1'b0;
  reg reset_n = 1'b0;
  reg clk_en = 1'b1;
  reg [7:0] ctl2_wdata = 8'h00;
  reg ctl2_we = 1'b0;
  reg [6:0] baud_reload_value = 7'h45;
  reg other_event_busy = 1'b0;
  reg [7:0] buf_wdata = 8'h00;
  reg buf_we = 1'b0;
  reg clr = 1'b0;
  reg scl_pull = 1'b0;
  reg sda_pull = 1'b0;
  wire [7:0] serial_control_two, transmit_buffer;
  wire start_seen, serial_irq_flag, write_collision_flag;
  wire bus_collision_flag, rs_busy, bus_clock_line_in, bus_data_line_in;
  wire bus_clock_line_oe, bus_data_line_oe;
  integer err_count = 0;
  integer n_compared = 0;
  integer n;

  i2crs_master i_i2crs_master
  (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .ctl2_wdata(ctl2_wdata),
    .ctl2_we(ctl2_we),
    .serial_control_two(serial_control_two),
    .baud_reload_value(baud_reload_value),
    .other_event_busy(other_event_busy),
    .buf_wdata(buf_wdata),
    .buf_we(buf_we),
    .transmit_buffer(transmit_buffer),
    .start_seen(start_seen),
    .start_seen_clr(clr),
    .serial_irq_flag(serial_irq_flag),
    .irq_clr(clr),
    .write_collision_flag(write_collision_flag),
    .write_collision_flag_clr(clr),
    .bus_collision_flag(bus_collision_flag),
    .bcol_clr(clr),
    .rs_busy(rs_busy),
    .bus_clock_line_in(bus_clock_line_in),
    .bus_clock_line_out(),
    .bus_clock_line_oe(bus_clock_line_oe),
    .bus_data_line_in(bus_data_line_in),
    .bus_data_line_out(),
    .bus_data_line_oe(bus_data_line_oe)
  );
  i2crs_bus_model i_i2crs_bus_model
  (
    .bus_clock_line_oe(bus_clock_line_oe),
    .bus_data_line_oe(bus_data_line_oe),
    .scl_pull(scl_pull),
    .sda_pull(sda_pull),
    .bus_clock_line_in(bus_clock_line_in),
    .bus_data_line_in(bus_data_line_in)
  );

  always #5 clock = ~clock;

  task cyc(input integer k);
    repeat (k) @(posedge clock) #1;
  endtask

  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  task wr_ctl(input [7:0] d);
    begin
      ctl2_wdata = d;
      ctl2_we = 1'b1;
      cyc(1);
      ctl2_we = 1'b0;
    end
  endtask

  task wr_buf(input [7:0] d);
    begin
      buf_wdata = d;
      buf_we = 1'b1;
      cyc(1);
      buf_we = 1'b0;
    end
  endtask

  task clear;
    begin
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
    end
  endtask

  // Waits for the clock line to be pulled, then counts until it is let go
  task scl_rel;
    begin
      for (n = 0; bus_clock_line_oe !== 1'b0 && n < 20; n = n + 1)
        cyc(1);
      for (n = 0; bus_clock_line_oe !== 1'b1 && n < 40; n = n + 1)
        cyc(1);
    end
  endtask

  task collide(input k);
    begin
      wr_ctl(8'h02);
      scl_rel;
      if (k)
      begin
        cyc(10);
        scl_pull = 1'b1;
        #40 scl_pull = 1'b0;
      end
      else
        sda_pull = 1'b1;
      for (n = 0; bus_collision_flag !== 1'b1 && n < 20; n = n + 1)
        cyc(1);
      cyc(1);
      chk({2'b00, rs_busy, serial_control_two[1], bus_clock_line_oe,
        bus_data_line_oe, serial_irq_flag, bus_collision_flag}, 8'h0D);
      sda_pull = 1'b0;
      clear;
      chk({6'h00, bus_collision_flag, write_collision_flag}, 8'h00);
    end
  endtask

  task final_report;
    begin
      if (err_count == 0 && n_compared > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  initial
  begin
    cyc(10);
    chk(serial_control_two | transmit_buffer, 8'h00);
    chk({1'b0, rs_busy, start_seen, serial_irq_flag, write_collision_flag,
      bus_collision_flag, bus_clock_line_oe, bus_data_line_oe}, 8'h03);
    reset_n = 1'b1;
    wr_ctl(8'h02);
    scl_rel;
    chk({7'h00, n > 5 && n < 20}, 8'h01);
    wr_buf(8'hA5);
    chk({transmit_buffer[6:0], write_collision_flag}, 8'h01);
    wr_ctl(8'hFD);
    chk(serial_control_two, 8'hE2);
    clk_en = 1'b0;
    wr_ctl(8'h00);
    cyc(19);
    chk(serial_control_two, 8'hE2);
    clk_en = 1'b1;
    for (n = 0; bus_data_line_oe !== 1'b0 && n < 200; n = n + 1)
      cyc(1);
    chk({7'h00, n > 60 && n < 80}, 8'h01);
    for (n = 0; serial_irq_flag !== 1'b1 && n < 200; n = n + 1)
      cyc(1);
    chk({7'h00, n > 67 && n < 73}, 8'h01);
    chk({serial_control_two[7:2], bus_data_line_oe, start_seen}, 8'hE1);
    wr_buf(8'h3C);
    chk(transmit_buffer, 8'h3C);
    clear;
    other_event_busy = 1'b1;
    wr_ctl(8'h02);
    cyc(2);
    chk({serial_control_two[7:1], rs_busy}, 8'h00);
    other_event_busy = 1'b0;
    wr_ctl(8'h02);
    other_event_busy = 1'b1;
    cyc(2);
    chk({serial_control_two[7:1], rs_busy}, 8'h00);
    other_event_busy = 1'b0;
    collide(1'b0);
    collide(1'b1);
    final_report;
  end

  initial
  begin
    #20000;
    err_count = err_count + 1;
    final_report;
  end
endmodule

bind i2crs_master i2crs_master_assertions i_chk
(
  .clock(clock),
  .reset_n(reset_n),
  .clk_en(clk_en),
  .ctl2_we(ctl2_we),
  .serial_control_two(serial_control_two),
  .buf_we(buf_we),
  .transmit_buffer(transmit_buffer),
  .serial_irq_flag(serial_irq_flag),
  .write_collision_flag(write_collision_flag),
  .bus_collision_flag(bus_collision_flag),
  .rs_busy(rs_busy),
  .bus_clock_line_oe(bus_clock_line_oe),
  .bus_data_line_oe(bus_data_line_oe)
);
